/* File: logic/cfgio_top.v */
// configuration registers and pin data path of four general io ports
//
// Function
// - extra high address bits on port pins captured on the address latch strobe
// - pins used by chip select decode are presented as latched address inputs
// - port a as data bus disables all its general io behaviour
// - peripheral buffer mode active only while map control bit 7 is one
// - peripheral mode relays the mcu data bus through all of port a
// - peripheral buffer tri-stated unless a peripheral select term is asserted
// - port c low four pins also carry jtag, which takes over their drive while enabled
// - config registers read and written by bus cycles at fixed offsets
// - each port register bit controls only the pin of the same index
// - mode, direction and driver registers clear to zero at reset
// - mode bit 0 gives mcu io, 1 address out; ports a, b only
// - direction bit 1 makes output, 0 input; all pins default input
// - ports a, b, c drive when direction bit or enable term is one
// - without an active enable term the direction bit alone decides
// - port d direction register holds only its three low bits
// - driver type bit 1 gives open drain, 0 push-pull
// - slew bit 1 gives fast slew, 0 slow slew
// - driver map: a, b od 7:4 slew 3:0; c all od; d slew 2:0
// - data in reads return live pin levels
// - data out drives enabled pins and reads back
`timescale 1ns/10ps
`include "cfgio_consts.vh"
module cfgio_top (
  input wire clk_i, // 25 MHz system clock
  input wire nrst_i, // synchronous reset, active low
  input wire io_cs_i, // io register space selected
  input wire rd_i, // register read strobe, one cycle
  input wire wr_i, // register write strobe, one cycle
  input wire [7:0] addr_i, // offset in io register space
  input wire [7:0] wdata_i, // register write data
  output reg [7:0] rdata_o, // register read data
  input wire [15:0] mcu_addr_i, // mcu address bus
  input wire addr_hi_sel_i, // port b address out carries a15:8
  input wire data_port_mode_i, // port a used as mcu data bus
  input wire [7:0] periph_wdata_i, // mcu data towards peripherals
  input wire periph_wr_i, // mcu cycle writes to peripheral
  input wire peripheral_select_a_i, // peripheral select term a
  input wire peripheral_select_b_i, // peripheral select term b
  output reg [7:0] periph_rdata_o, // peripheral data towards mcu
  input wire [7:0] oe_term_a_i, // logic array enable terms port a
  input wire [7:0] oe_term_b_i, // logic array enable terms port b
  input wire [7:0] oe_term_c_i, // logic array enable terms port c
  input wire [2:0] oe_term_d_i, // logic array enable terms port d
  input wire [7:0] cs_decode_use_a_i, // port a bits used by decode
  input wire [7:0] cs_decode_use_b_i, // port b bits used by decode
  input wire [7:0] cs_decode_use_c_i, // port c bits used by decode
  input wire [2:0] cs_decode_use_d_i, // port d bits used by decode
  output reg [7:0] addr_in_a_o, // address inputs from port a
  output reg [7:0] addr_in_b_o, // address inputs from port b
  output reg [7:0] addr_in_c_o, // address inputs from port c
  output reg [2:0] addr_in_d_o, // address inputs from port d
  input wire jtag_en_i, // jtag owns port c low pins
  input wire jtag_tdo_i, // jtag serial out
  input wire jtag_tdo_en_i, // jtag serial out enable
  output reg jtag_tck_o, // jtag clock from pin
  output reg jtag_tms_o, // jtag mode select from pin
  output reg jtag_tdi_o, // jtag serial in from pin
  input wire [7:0] pa_i, // port a pin levels
  output reg [7:0] pa_o, // port a pin drive value
  output reg [7:0] pa_oe_n_o, // port a enable, low drives
  input wire [7:0] pb_i, // port b pin levels
  output reg [7:0] pb_o, // port b pin drive value
  output reg [7:0] pb_oe_n_o, // port b enable, low drives
  input wire [7:0] pc_i, // port c pin levels
  output reg [7:0] pc_o, // port c pin drive value
  output reg [7:0] pc_oe_n_o, // port c enable, low drives
  input wire [2:0] pd_i, // port d pin levels
  output reg [2:0] pd_o, // port d pin drive value
  output reg [2:0] pd_oe_n_o, // port d enable, low drives
  output reg [3:0] slew_fast_a_o, // port a 3:0 fast slew
  output reg [3:0] slew_fast_b_o, // port b 3:0 fast slew
  output reg [2:0] slew_fast_d_o // port d 2:0 fast slew
);
  // configuration and data out registers
  reg [7:0] mode_a_reg;
  reg [7:0] mode_b_reg;
  reg [7:0] dir_a_reg;
  reg [7:0] dir_b_reg;
  reg [7:0] dir_c_reg;
  reg [2:0] dir_d_reg;
  reg [7:0] drv_a_reg;
  reg [7:0] drv_b_reg;
  reg [7:0] drv_c_reg;
  reg [2:0] drv_d_reg;
  reg [7:0] dout_a_reg;
  reg [7:0] dout_b_reg;
  reg [7:0] dout_c_reg;
  reg [2:0] dout_d_reg;
  reg [7:0] map_ctrl_reg;
  // input latch cells and latched address
  reg [7:0] ilc_a_reg;
  reg [7:0] ilc_b_reg;
  reg [7:0] ilc_c_reg;
  reg [2:0] ilc_d_reg;
  reg [15:0] addr_lat_reg;
  reg strobe_dly_reg;

  wire [26:0] pins_sync;
  wire [7:0] pa_s;
  wire [7:0] pb_s;
  wire [7:0] pc_s;
  wire [2:0] pd_s;
  wire strobe_rise;
  wire [1:0] sel_port;
  wire [2:0] sel_reg;
  wire wr_hit;
  wire periph_on;
  wire periph_sel;

  cfgio_sync #(
    .W(27)
  ) u_pin_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({pd_i, pc_i, pb_i, pa_i}),
    .sync_o(pins_sync)
  );

  assign pa_s = pins_sync[7:0];
  assign pb_s = pins_sync[15:8];
  assign pc_s = pins_sync[23:16];
  assign pd_s = pins_sync[26:24];
  assign strobe_rise = pd_s[`CFGIO_STROBE_BIT] & ~strobe_dly_reg;

  assign sel_port = addr_i[`CFGIO_PORT_HI:`CFGIO_PORT_LO];
  assign sel_reg = addr_i[`CFGIO_REG_HI:`CFGIO_REG_LO];
  assign wr_hit = io_cs_i & wr_i & (addr_i[7:5] == 3'h0);
  assign periph_on = map_ctrl_reg[`CFGIO_PERIPH_BIT] & ~data_port_mode_i;
  assign periph_sel = peripheral_select_a_i | peripheral_select_b_i;

  // active low enable per bit; open drain bits only ever pull low
  function [7:0] oe_n_f;
    input [7:0] en;
    input [7:0] od;
    input [7:0] val;
    begin
      oe_n_f = ~(en & (~od | ~val));
    end
  endfunction

  // open drain bits hold the drive value low so release means high-z
  function [7:0] val_f;
    input [7:0] od;
    input [7:0] val;
    begin
      val_f = val & ~od;
    end
  endfunction

  // byte read decode for one port block
  function [7:0] rd_port_f;
    input [2:0] r;
    input [7:0] din;
    input [7:0] dout;
    input [7:0] dir;
    input [7:0] drv;
    input [7:0] mode;
    begin
      case (r)
        `CFGIO_REG_DATA_IN: rd_port_f = din;
        `CFGIO_REG_DATA_OUT: rd_port_f = dout;
        `CFGIO_REG_DIRECTION: rd_port_f = dir;
        `CFGIO_REG_DRIVER: rd_port_f = drv;
        `CFGIO_REG_MODE: rd_port_f = mode;
        default: rd_port_f = 8'h00;
      endcase
    end
  endfunction

  // register writes, latch cells and strobe edge
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      mode_a_reg <= `CFGIO_RST_BYTE;
      mode_b_reg <= `CFGIO_RST_BYTE;
      dir_a_reg <= `CFGIO_RST_BYTE;
      dir_b_reg <= `CFGIO_RST_BYTE;
      dir_c_reg <= `CFGIO_RST_BYTE;
      dir_d_reg <= `CFGIO_RST_D;
      drv_a_reg <= `CFGIO_RST_BYTE;
      drv_b_reg <= `CFGIO_RST_BYTE;
      drv_c_reg <= `CFGIO_RST_BYTE;
      drv_d_reg <= `CFGIO_RST_D;
      dout_a_reg <= `CFGIO_RST_BYTE;
      dout_b_reg <= `CFGIO_RST_BYTE;
      dout_c_reg <= `CFGIO_RST_BYTE;
      dout_d_reg <= `CFGIO_RST_D;
      map_ctrl_reg <= `CFGIO_RST_BYTE;
      ilc_a_reg <= `CFGIO_RST_BYTE;
      ilc_b_reg <= `CFGIO_RST_BYTE;
      ilc_c_reg <= `CFGIO_RST_BYTE;
      ilc_d_reg <= `CFGIO_RST_D;
      addr_lat_reg <= 16'h0000;
      strobe_dly_reg <= 1'b0;
    end else begin
      strobe_dly_reg <= pd_s[`CFGIO_STROBE_BIT];
      if (strobe_rise) begin
        ilc_a_reg <= pa_s;
        ilc_b_reg <= pb_s;
        ilc_c_reg <= pc_s;
        ilc_d_reg <= pd_s;
        addr_lat_reg <= mcu_addr_i;
      end
      if (io_cs_i & wr_i & (addr_i == `CFGIO_MAP_CTRL_ADDR)) begin
        map_ctrl_reg <= wdata_i;
      end
      // port a registers frozen while it serves as the data bus
      if (wr_hit & (sel_port == `CFGIO_PORT_A) & ~data_port_mode_i) begin
        case (sel_reg)
          `CFGIO_REG_DATA_OUT: dout_a_reg <= wdata_i;
          `CFGIO_REG_DIRECTION: dir_a_reg <= wdata_i;
          `CFGIO_REG_DRIVER: drv_a_reg <= wdata_i;
          `CFGIO_REG_MODE: mode_a_reg <= wdata_i;
          default: ;
        endcase
      end
      if (wr_hit & (sel_port == `CFGIO_PORT_B)) begin
        case (sel_reg)
          `CFGIO_REG_DATA_OUT: dout_b_reg <= wdata_i;
          `CFGIO_REG_DIRECTION: dir_b_reg <= wdata_i;
          `CFGIO_REG_DRIVER: drv_b_reg <= wdata_i;
          `CFGIO_REG_MODE: mode_b_reg <= wdata_i;
          default: ;
        endcase
      end
      if (wr_hit & (sel_port == `CFGIO_PORT_C)) begin
        case (sel_reg)
          `CFGIO_REG_DATA_OUT: dout_c_reg <= wdata_i;
          `CFGIO_REG_DIRECTION: dir_c_reg <= wdata_i;
          `CFGIO_REG_DRIVER: drv_c_reg <= wdata_i;
          default: ;
        endcase
      end
      if (wr_hit & (sel_port == `CFGIO_PORT_D)) begin
        case (sel_reg)
          `CFGIO_REG_DATA_OUT: dout_d_reg <= wdata_i[2:0];
          `CFGIO_REG_DIRECTION: dir_d_reg <= wdata_i[2:0];
          `CFGIO_REG_DRIVER: drv_d_reg <= wdata_i[2:0];
          default: ;
        endcase
      end
    end
  end

  // register read path
  reg [7:0] rdata_next;
  always @* begin
    rdata_next = 8'h00;
    if (addr_i == `CFGIO_MAP_CTRL_ADDR) begin
      rdata_next = map_ctrl_reg;
    end else if (addr_i[7:5] == 3'h0) begin
      case (sel_port)
        `CFGIO_PORT_A: begin
          if (!data_port_mode_i) begin
            rdata_next = rd_port_f(sel_reg, pa_s, dout_a_reg, dir_a_reg, drv_a_reg,
              mode_a_reg);
          end
        end
        `CFGIO_PORT_B: rdata_next = rd_port_f(sel_reg, pb_s, dout_b_reg, dir_b_reg,
          drv_b_reg, mode_b_reg);
        `CFGIO_PORT_C: rdata_next = rd_port_f(sel_reg, pc_s, dout_c_reg, dir_c_reg,
          drv_c_reg, 8'h00);
        `CFGIO_PORT_D: rdata_next = rd_port_f(sel_reg, {5'h00, pd_s}, {5'h00, dout_d_reg},
          {5'h00, dir_d_reg}, {5'h00, drv_d_reg}, 8'h00);
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // pin drive computation
  reg [7:0] en_a;
  reg [7:0] val_a;
  reg [7:0] od_a;
  reg [7:0] en_b;
  reg [7:0] val_b;
  reg [7:0] en_c;
  reg [7:0] val_c;
  reg [2:0] en_d;
  reg [7:0] addr_b_src;
  always @* begin
    // bitwise or keeps each pin tied to its own bit index
    en_a = dir_a_reg | oe_term_a_i;
    val_a = (mode_a_reg & addr_lat_reg[7:0]) | (~mode_a_reg & dout_a_reg);
    od_a = {drv_a_reg[`CFGIO_OD_HI:`CFGIO_OD_LO], 4'h0};
    if (data_port_mode_i) begin
      en_a = 8'h00;
      val_a = 8'h00;
    end else if (periph_on) begin
      // buffer direction follows the mcu cycle, released when unselected
      en_a = {8{periph_sel & periph_wr_i}};
      val_a = periph_wdata_i;
      od_a = 8'h00;
    end
    addr_b_src = addr_hi_sel_i ? addr_lat_reg[15:8] : addr_lat_reg[7:0];
    en_b = dir_b_reg | oe_term_b_i;
    val_b = (mode_b_reg & addr_b_src) | (~mode_b_reg & dout_b_reg);
    en_c = dir_c_reg | oe_term_c_i;
    val_c = dout_c_reg;
    if (jtag_en_i) begin
      // jtag takes the low pins; tdo drives only when the tap enables it
      en_c = (en_c & ~`CFGIO_JTAG_MASK) |
        ({7'h00, jtag_tdo_en_i} << `CFGIO_JTAG_TDO);
      val_c = (val_c & ~`CFGIO_JTAG_MASK) | ({7'h00, jtag_tdo_i} << `CFGIO_JTAG_TDO);
    end
    en_d = dir_d_reg | oe_term_d_i;
  end

  // registered pin outputs
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      pa_o <= 8'h00;
      pa_oe_n_o <= 8'hff;
      pb_o <= 8'h00;
      pb_oe_n_o <= 8'hff;
      pc_o <= 8'h00;
      pc_oe_n_o <= 8'hff;
      pd_o <= 3'h0;
      pd_oe_n_o <= 3'h7;
      slew_fast_a_o <= 4'h0;
      slew_fast_b_o <= 4'h0;
      slew_fast_d_o <= 3'h0;
      rdata_o <= 8'h00;
      periph_rdata_o <= 8'h00;
      addr_in_a_o <= 8'h00;
      addr_in_b_o <= 8'h00;
      addr_in_c_o <= 8'h00;
      addr_in_d_o <= 3'h0;
      jtag_tck_o <= 1'b0;
      jtag_tms_o <= 1'b0;
      jtag_tdi_o <= 1'b0;
    end else begin
      pa_o <= val_f(od_a, val_a);
      pa_oe_n_o <= oe_n_f(en_a, od_a, val_a);
      pb_o <= val_f({drv_b_reg[`CFGIO_OD_HI:`CFGIO_OD_LO], 4'h0}, val_b);
      pb_oe_n_o <= oe_n_f(en_b, {drv_b_reg[`CFGIO_OD_HI:`CFGIO_OD_LO], 4'h0}, val_b);
      pc_o <= val_f(drv_c_reg, val_c);
      pc_oe_n_o <= oe_n_f(en_c, drv_c_reg, val_c);
      pd_o <= dout_d_reg;
      pd_oe_n_o <= ~en_d;
      slew_fast_a_o <= data_port_mode_i ? 4'h0 : drv_a_reg[`CFGIO_SLEW_HI:`CFGIO_SLEW_LO];
      slew_fast_b_o <= drv_b_reg[`CFGIO_SLEW_HI:`CFGIO_SLEW_LO];
      slew_fast_d_o <= drv_d_reg;
      if (io_cs_i & rd_i) begin
        rdata_o <= rdata_next;
      end
      // peripheral reads hand port a levels back toward the mcu
      if (periph_on & periph_sel & ~periph_wr_i) begin
        periph_rdata_o <= pa_s;
      end
      // decode inputs see the strobe-latched value, others see the live pin
      addr_in_a_o <= (cs_decode_use_a_i & ilc_a_reg) | (~cs_decode_use_a_i & pa_s);
      addr_in_b_o <= (cs_decode_use_b_i & ilc_b_reg) | (~cs_decode_use_b_i & pb_s);
      addr_in_c_o <= (cs_decode_use_c_i & ilc_c_reg) | (~cs_decode_use_c_i & pc_s);
      addr_in_d_o <= (cs_decode_use_d_i & ilc_d_reg) | (~cs_decode_use_d_i & pd_s);
      jtag_tck_o <= jtag_en_i & pc_s[`CFGIO_JTAG_TCK];
      jtag_tms_o <= jtag_en_i & pc_s[`CFGIO_JTAG_TMS];
      jtag_tdi_o <= jtag_en_i & pc_s[`CFGIO_JTAG_TDI];
    end
  end
endmodule

/* File: pkg/cfgio_consts.vh */
// register offsets, field positions, reset values and pin roles of the configurable io port
`ifndef CFGIO_CONSTS_VH
`define CFGIO_CONSTS_VH
// address within the io register space: [4:3] port, [2:0] register
`define CFGIO_ADDR_W 8
`define CFGIO_PORT_A 2'h0
`define CFGIO_PORT_B 2'h1
`define CFGIO_PORT_C 2'h2
`define CFGIO_PORT_D 2'h3
`define CFGIO_REG_DATA_IN 3'h0
`define CFGIO_REG_DATA_OUT 3'h1
`define CFGIO_REG_DIRECTION 3'h2
`define CFGIO_REG_DRIVER 3'h3
`define CFGIO_REG_MODE 3'h4
`define CFGIO_MAP_CTRL_ADDR 8'h20
`define CFGIO_PORT_HI 4
`define CFGIO_PORT_LO 3
`define CFGIO_REG_HI 2
`define CFGIO_REG_LO 0
// memory map control: peripheral buffer enable
`define CFGIO_PERIPH_BIT 7
// reset values
`define CFGIO_RST_BYTE 8'h00
`define CFGIO_RST_D 3'h0
// driver config split for ports a and b
`define CFGIO_OD_HI 7
`define CFGIO_OD_LO 4
`define CFGIO_SLEW_HI 3
`define CFGIO_SLEW_LO 0
// jtag pin roles on port c
`define CFGIO_JTAG_TCK 0
`define CFGIO_JTAG_TMS 1
`define CFGIO_JTAG_TDI 2
`define CFGIO_JTAG_TDO 3
`define CFGIO_JTAG_MASK 8'h0f
// port d pin carrying the address latch strobe
`define CFGIO_STROBE_BIT 0
`endif

/* File: logic/cfgio_sync.v */
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module cfgio_sync #(
  parameter W = 8
) (
  input wire clk_i, // system clock
  input wire nrst_i, // synchronous reset, active low
  input wire [W-1:0] async_i, // raw pin levels
  output reg [W-1:0] sync_o // synchronised levels
);
  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_reg <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule

/* File: verification/cfgio_properties.sv */
// concurrent checks of the configurable io port seen at its top ports
`timescale 1ns/10ps
module cfgio_properties (
  input wire clk_i, // clock
  input wire nrst_i, // sync reset, active low
  input wire io_cs_i, // space select
  input wire rd_i, // read strobe
  input wire wr_i, // write strobe
  input wire [7:0] addr_i, // register offset
  input wire [7:0] wdata_i, // write data
  input wire [7:0] rdata_o, // read data
  input wire data_port_mode_i, // port a is data bus
  input wire [7:0] periph_wdata_i, // data to peripherals
  input wire periph_wr_i, // peripheral write
  input wire peripheral_select_a_i, // select term a
  input wire peripheral_select_b_i, // select term b
  input wire [7:0] oe_term_b_i, // enable terms port b
  input wire [7:0] pa_o, // port a drive value
  input wire [7:0] pa_oe_n_o, // port a enable
  input wire [7:0] pb_oe_n_o, // port b enable
  input wire jtag_en_i, // jtag owns port c
  input wire jtag_tck_o, // jtag clock
  input wire jtag_tms_o, // jtag mode
  input wire jtag_tdi_o, // jtag data in
  input wire [3:0] slew_fast_a_o // port a slew
);
  reg periph_q;
  // mirrors the peripheral enable bit so the pin checks know the mode
  always @(posedge clk_i) begin
    if (!nrst_i)
      periph_q <= 1'b0;
    else if (io_cs_i && wr_i && addr_i == 8'h20)
      periph_q <= wdata_i[7];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_RST_IDLE: assert property (disable iff (1'b0) !nrst_i |=> pa_oe_n_o == 8'hff &&
    pb_oe_n_o == 8'hff && rdata_o == 8'h00 && slew_fast_a_o == 4'h0)
    else $error("outputs not idle after reset");
  AST_OE_TERM: assert property (nrst_i |=>
    (pb_oe_n_o[3:0] & $past(oe_term_b_i[3:0])) == 4'h0)
    else $error("enable term did not drive pin");
  AST_PERIPH_HIZ: assert property (periph_q && !data_port_mode_i &&
    !peripheral_select_a_i && !peripheral_select_b_i |=> pa_oe_n_o == 8'hff)
    else $error("peripheral buffer driven while unselected");
  AST_PERIPH_DRV: assert property (periph_q && !data_port_mode_i && periph_wr_i &&
    (peripheral_select_a_i || peripheral_select_b_i) |=>
    pa_oe_n_o == 8'h00 && pa_o == $past(periph_wdata_i))
    else $error("peripheral write not relayed");
  AST_RD_HOLD: assert property (!(io_cs_i && rd_i) |=> $stable(rdata_o))
    else $error("read data changed without read");
  AST_UNMAPPED: assert property (io_cs_i && rd_i && addr_i[7:5] != 3'h0 &&
    addr_i != 8'h20 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_DIR_D: assert property (io_cs_i && rd_i && addr_i == 8'h1a |=>
    rdata_o[7:3] == 5'h00)
    else $error("port d direction upper bits set");
  AST_DATA_PORT: assert property (io_cs_i && rd_i && data_port_mode_i &&
    addr_i[7:3] == 5'h00 |=> rdata_o == 8'h00)
    else $error("port a register visible in data port mode");
  AST_JTAG_OFF: assert property (!jtag_en_i |=>
    !jtag_tck_o && !jtag_tms_o && !jtag_tdi_o)
    else $error("jtag signals active while disabled");
endmodule
bind cfgio_top cfgio_properties i_cfgio_properties (.clk_i, .nrst_i, .io_cs_i, .rd_i,
  .wr_i, .addr_i, .wdata_i, .rdata_o, .data_port_mode_i, .periph_wdata_i, .periph_wr_i,
  .peripheral_select_a_i, .peripheral_select_b_i, .oe_term_b_i, .pa_o, .pa_oe_n_o,
  .pb_oe_n_o, .jtag_en_i, .jtag_tck_o, .jtag_tms_o, .jtag_tdi_o, .slew_fast_a_o);

/* File: verification/cfgio_mcu_model.sv */
// bus master model of the microcontroller reaching the io register space
`timescale 1ns/10ps
module cfgio_mcu_model (
  input wire clk_i, // system clock
  input wire [7:0] rdata_o, // read data from device
  output reg io_cs_i, // space select
  output reg rd_i, // read strobe
  output reg wr_i, // write strobe
  output reg [7:0] addr_i, // register offset
  output reg [7:0] wdata_i // write data
);
  initial begin
    io_cs_i = 1'b0;
    rd_i = 1'b0;
    wr_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
  end
  task idle;
    begin
      io_cs_i = 1'b0;
      rd_i = 1'b0;
      wr_i = 1'b0;
      // a released bus must not keep showing the last value
      addr_i = ~addr_i;
      wdata_i = ~wdata_i;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_i);
      io_cs_i = 1'b1;
      wr_i = 1'b1;
      addr_i = a;
      wdata_i = d;
      @(negedge clk_i);
      idle;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk_i);
      io_cs_i = 1'b1;
      rd_i = 1'b1;
      addr_i = a;
      @(negedge clk_i);
      d = rdata_o;
      idle;
    end
  endtask
endmodule

/* File: verification/cfgio_top_tb.sv */
// self-checking bench of the configurable io port
`timescale 1ns/10ps
module cfgio_top_tb;
  reg clk_i, nrst_i = 1'b0, addr_hi_sel_i = 1'b0, data_port_mode_i = 1'b0;
  reg periph_wr_i = 1'b0, peripheral_select_a_i = 1'b0, peripheral_select_b_i = 1'b0;
  reg jtag_en_i = 1'b0, jtag_tdo_i = 1'b0, jtag_tdo_en_i = 1'b0;
  reg [15:0] mcu_addr_i = 16'h0000;
  reg [7:0] periph_wdata_i = 8'h00, oe_term_a_i = 8'h00, oe_term_b_i = 8'h00;
  reg [7:0] oe_term_c_i = 8'h00, cs_decode_use_a_i = 8'h00, cs_decode_use_b_i = 8'h00;
  reg [7:0] cs_decode_use_c_i = 8'h00, pa_i = 8'h00, pb_i = 8'h00, pc_i = 8'h00;
  reg [2:0] oe_term_d_i = 3'h0, cs_decode_use_d_i = 3'h0, pd_i = 3'h0;
  wire io_cs_i, rd_i, wr_i, jtag_tck_o, jtag_tms_o, jtag_tdi_o;
  wire [7:0] addr_i, wdata_i, rdata_o, periph_rdata_o, addr_in_a_o, addr_in_b_o;
  wire [7:0] addr_in_c_o, pa_o, pa_oe_n_o, pb_o, pb_oe_n_o, pc_o, pc_oe_n_o;
  wire [2:0] addr_in_d_o, pd_o, pd_oe_n_o, slew_fast_d_o;
  wire [3:0] slew_fast_a_o, slew_fast_b_o;
  integer fails = 0, n_compared = 0, cycles = 0, i;
  reg [7:0] v, w, u;
  reg [1:0] p;
  reg [2:0] r;
  cfgio_top i_cfgio_top (.*);
  cfgio_mcu_model i_cfgio_mcu_model (.*);
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    // the whole run needs a few hundred cycles
    if (cycles == 20000) begin
      fails = fails + 1;
      close_out;
    end
  end
  task close_out;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk_i);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    i_cfgio_mcu_model.wr(a, d);
  endtask
  task rc(input [7:0] a, input [7:0] e);
    reg [7:0] g;
    begin
      i_cfgio_mcu_model.rd(a, g);
      chk(g, e);
    end
  endtask
  task rst;
    begin
      nrst_i = 1'b0;
      cyc(10);
      nrst_i = 1'b1;
    end
  endtask
  // port c and d have no mode register, port d keeps three bits
  function [7:0] exp_rb(input [1:0] pp, input [2:0] rr, input [7:0] d);
    begin
      exp_rb = d;
      if (rr == 3'h4 && pp[1])
        exp_rb = 8'h00;
      if (pp == 2'h3)
        exp_rb = exp_rb & 8'h07;
    end
  endfunction
  initial begin
    void'($urandom(76));
    rst;
    // sized sum keeps the port field; covers data out to mode on all four ports
    for (i = 0; i < 16; i = i + 1)
      rc({3'h0, i[3:2], 3'h1 + {1'b0, i[1:0]}}, 8'h00);
    chk(pa_oe_n_o, 8'hff);
    $display("reset values done");
    for (i = 0; i < 24; i = i + 1) begin
      p = $urandom % 4;
      r = 3'h1 + $urandom % 4;
      v = $urandom;
      wr({3'h0, p, r}, v);
      rc({3'h0, p, r}, exp_rb(p, r, v));
    end
    wr(8'h40, 8'hff);
    rc(8'h40, 8'h00);
    wr(8'h1a, 8'hff);
    rc(8'h1a, 8'h07);
    $display("register access done");
    rst;
    v = $urandom;
    w = $urandom;
    wr(8'h02, v);
    wr(8'h01, w);
    cyc(3);
    chk(pa_oe_n_o, ~v);
    chk(pa_o & v, w & v);
    wr(8'h02, 8'h00);
    u = $urandom;
    oe_term_a_i = u;
    cyc(3);
    chk(pa_oe_n_o, ~u);
    oe_term_a_i = 8'h00;
    oe_term_b_i = 8'h0c;
    cyc(3);
    chk(pb_oe_n_o, 8'hf3);
    oe_term_b_i = 8'h00;
    wr(8'h0b, 8'hf0);
    wr(8'h0a, 8'hff);
    wr(8'h09, 8'h5a);
    cyc(3);
    chk(pb_oe_n_o, 8'h50);
    chk(pb_o, 8'h0a);
    chk({4'h0, slew_fast_b_o}, 8'h00);
    wr(8'h0b, 8'h0f);
    wr(8'h13, 8'hff);
    wr(8'h12, 8'hff);
    wr(8'h11, 8'h3c);
    wr(8'h1b, 8'h07);
    wr(8'h19, 8'h05);
    wr(8'h1a, 8'h03);
    wr(8'h03, 8'h0a);
    cyc(3);
    chk({5'h0, pd_oe_n_o}, 8'h04);
    chk({5'h0, pd_o}, 8'h05);
    chk({4'h0, slew_fast_a_o}, 8'h0a);
    chk({4'h0, slew_fast_b_o}, 8'h0f);
    chk(pb_oe_n_o, 8'h00);
    chk(pc_oe_n_o, 8'h3c);
    chk(pc_o, 8'h00);
    chk({5'h0, slew_fast_d_o}, 8'h07);
    $display("pin drive done");
    rst;
    mcu_addr_i = $urandom;
    v = $urandom;
    w = $urandom;
    pc_i = v;
    pb_i = w;
    cs_decode_use_c_i = 8'hff;
    wr(8'h04, 8'hff);
    wr(8'h02, 8'hff);
    cyc(3);
    pd_i = 3'h1;
    cyc(3);
    pd_i = 3'h0;
    pc_i = ~v;
    cyc(4);
    chk(pa_o, mcu_addr_i[7:0]);
    chk(addr_in_c_o, v);
    chk(addr_in_b_o, w);
    wr(8'h0c, 8'hff);
    wr(8'h0a, 8'hff);
    addr_hi_sel_i = 1'b1;
    cyc(3);
    chk(pb_o, mcu_addr_i[15:8]);
    addr_hi_sel_i = 1'b0;
    rc(8'h10, ~v);
    $display("address modes done");
    wr(8'h02, 8'h0f);
    wr(8'h04, 8'h00);
    data_port_mode_i = 1'b1;
    wr(8'h02, 8'hff);
    rc(8'h02, 8'h00);
    data_port_mode_i = 1'b0;
    rc(8'h02, 8'h0f);
    v = $urandom;
    wr(8'h20, 8'h80);
    peripheral_select_a_i = 1'b1;
    periph_wr_i = 1'b1;
    periph_wdata_i = v;
    cyc(3);
    chk(pa_oe_n_o, 8'h00);
    chk(pa_o, v);
    peripheral_select_a_i = 1'b0;
    cyc(3);
    chk(pa_oe_n_o, 8'hff);
    peripheral_select_b_i = 1'b1;
    periph_wr_i = 1'b0;
    pa_i = ~v;
    cyc(4);
    chk(periph_rdata_o, ~v);
    wr(8'h20, 8'h00);
    periph_wr_i = 1'b1;
    cyc(3);
    chk(pa_oe_n_o, 8'hf0);
    jtag_en_i = 1'b1;
    jtag_tdo_en_i = 1'b1;
    jtag_tdo_i = 1'b1;
    pc_i = 8'h05;
    cyc(4);
    chk({5'h0, jtag_tdi_o, jtag_tms_o, jtag_tck_o}, 8'h05);
    chk(pc_oe_n_o, 8'hf7);
    chk(pc_o, 8'h08);
    jtag_en_i = 1'b0;
    jtag_tdo_en_i = 1'b0;
    jtag_tdo_i = 1'b0;
    $display("shared modes done");
    close_out;
  end
endmodule
